// [src/port_power_pkg.sv]
package port_power_pkg;

   localparam int          NUM_PORTS        = 4;
   localparam logic [7:0]  CHARGE_EN_OFFSET = 8'hD0;
   localparam logic [7:0]  CHARGE_EN_RESET  = 8'h00;
   localparam int          CHARGE_EN_LSB    = 1;
   localparam int          SYNC_STAGES      = 2;

   typedef enum logic [1:0] {
      CFG_DEFAULT_SELF = 2'h0,
      CFG_SMBUS        = 2'h1,
      CFG_DEFAULT_BUS  = 2'h2,
      CFG_EEPROM       = 2'h3
   } cfg_sel_e;

   // gray-coded along reset -> sample -> config -> run
   typedef enum logic [1:0] {
      ST_RESET  = 2'h0,
      ST_SAMPLE = 2'h1,
      ST_CONFIG = 2'h3,
      ST_RUN    = 2'h2
   } seq_state_e;

   typedef struct packed {
      logic       valid;
      logic [7:0] addr;
      logic [7:0] data;
   } reg_write_s;

   typedef struct packed {
      logic       self_powered;
      logic       strap_enabled;
      logic       individual_switch;
      logic       individual_sense;
      logic       external_cfg;
   } hub_mode_s;

endpackage : port_power_pkg

// [src/hub_port_power_config.sv]
// Overview of operation
// (RULE1) charging ports power on after configuration
// (RULE2) no wait for enumeration or vbus
// (RULE3) overcurrent drops that port's power enable
// (RULE4) re-enable only by host request or reset
// (RULE5) persistent short reported to attached host
// (RULE6) charge register bit n enables port n
// (RULE7) each enabled charging port drives power
// (RULE8) default mode takes charging from straps
// (RULE9) config select sampled right after reset
// (RULE10) code 00: self-powered default with straps
// (RULE11) code 10: default but bus-powered
// (RULE12) code 01: smbus host writes registers
// (RULE13) code 11: registers loaded from eeprom
// (RULE14) external modes ignore all straps
// (RULE15) internal modes apply strap options
// (RULE16) strap high means one, enables charging
// (RULE17) overcurrent latch held until host or reset
// (RULE18) power off during reset and configuration
`timescale 1ns/1ps
`default_nettype none

module hub_port_power_config
   import port_power_pkg::*;
#(
   parameter int PORTS = port_power_pkg::NUM_PORTS
) (
   input  wire logic                          CLK,
   input  wire logic                          SRST,
   input  wire logic [1:0]                    CFG_SEL,
   input  wire logic [PORTS:1]                CHARGE_ENABLE_STRAP,
   input  wire port_power_pkg::reg_write_s    CFG_WRITE,
   input  wire logic                          CFG_LOAD_DONE,
   input  wire logic [PORTS:1]                OVER_CURRENT,
   input  wire logic [PORTS:1]                HOST_POWER_REQ,
   input  wire logic                          HUB_ENUMERATED,
   input  wire logic                          UPSTREAM_VBUS_DETECT,
   output logic [PORTS:1]                     PORT_POWER_ENABLE,
   output logic [PORTS:1]                     OVER_CURRENT_REPORT,
   output logic [7:0]                         PORT_CHARGE_ENABLE,
   output port_power_pkg::hub_mode_s          HUB_MODE,
   output logic                               CONFIG_DONE
);
   import port_power_pkg::*;

   // select, strap, overcurrent and load-done pins synchronised before logic reads them
   logic [1:0]       cfg_meta_reg;
   logic [1:0]       cfg_sync_reg;
   logic [PORTS:1]   strap_meta_reg;
   logic [PORTS:1]   strap_sync_reg;
   logic [PORTS:1]   oc_meta_reg;
   logic [PORTS:1]   oc_sync_reg;
   logic             load_meta_reg;
   logic             load_sync_reg;

   seq_state_e       state_reg;
   seq_state_e       state_next;
   logic [1:0]       settle_reg;
   cfg_sel_e         sel_reg;
   hub_mode_s        mode_reg;
   hub_mode_s        mode_next;
   logic [7:0]       charge_reg;
   logic [PORTS:1]   oc_latch_reg;
   logic [PORTS:1]   host_on_reg;
   logic [PORTS:1]   power_reg;
   logic [PORTS:1]   report_reg;

   wire              is_external;
   wire              reg_hit;
   wire              settled;
   wire [PORTS:1]    charge_ports;
   wire [PORTS:1]    power_next;

   always_ff @(posedge CLK) begin
      cfg_meta_reg   <= CFG_SEL;
      cfg_sync_reg   <= cfg_meta_reg;
      strap_meta_reg <= CHARGE_ENABLE_STRAP;
      strap_sync_reg <= strap_meta_reg;
      oc_meta_reg    <= OVER_CURRENT;
      oc_sync_reg    <= oc_meta_reg;
      load_meta_reg  <= CFG_LOAD_DONE;
      load_sync_reg  <= load_meta_reg;
   end

   // pins need the synchroniser depth to be valid after release
   assign settled = (settle_reg == 2'(SYNC_STAGES));

   always_ff @(posedge CLK) begin
      if (SRST) begin
         settle_reg <= 2'h0;
      end else if (!settled) begin
         settle_reg <= settle_reg + 2'h1;
      end
   end

   assign is_external = sel_reg[0];                              // (RULE14)
   assign reg_hit     = CFG_WRITE.valid &&
                        (CFG_WRITE.addr == CHARGE_EN_OFFSET);

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_RESET: begin
            state_next = ST_SAMPLE;
         end
         ST_SAMPLE: begin
            if (settled) begin
               state_next = ST_CONFIG;                           // (RULE9)
            end
         end
         ST_CONFIG: begin
            if (!is_external || load_sync_reg) begin
               state_next = ST_RUN;
            end
         end
         ST_RUN: begin
            state_next = ST_RUN;
         end
         default: begin
            state_next = ST_RESET;
         end
      endcase
   end

   always_comb begin
      mode_next                   = '0;
      mode_next.individual_switch = 1'b1;                        // (RULE10)
      mode_next.individual_sense  = 1'b1;
      case (cfg_sel_e'(cfg_sync_reg))
         CFG_DEFAULT_SELF: begin
            mode_next.self_powered  = 1'b1;                      // (RULE10)
            mode_next.strap_enabled = 1'b1;
         end
         CFG_DEFAULT_BUS: begin
            mode_next.strap_enabled = 1'b1;                      // (RULE11)
         end
         CFG_SMBUS: begin
            mode_next.external_cfg  = 1'b1;                      // (RULE12)
         end
         CFG_EEPROM: begin
            mode_next.external_cfg  = 1'b1;                      // (RULE13)
         end
         default: begin
            mode_next = '0;
         end
      endcase
   end

   always_ff @(posedge CLK) begin
      if (SRST) begin
         state_reg <= ST_RESET;
         sel_reg   <= CFG_DEFAULT_SELF;
         mode_reg  <= '0;
      end else begin
         state_reg <= state_next;
         if (state_reg == ST_SAMPLE && settled) begin
            sel_reg  <= cfg_sel_e'(cfg_sync_reg);                // (RULE9)
            mode_reg <= mode_next;
         end
      end
   end

   // charging enable: straps in default modes, register otherwise
   always_ff @(posedge CLK) begin
      if (SRST) begin
         charge_reg <= CHARGE_EN_RESET;
      end else if (state_reg == ST_SAMPLE && settled &&
                   !cfg_sync_reg[0]) begin                       // (RULE15)
         charge_reg <= 8'({strap_sync_reg,                       // (RULE8)
                           1'b0});                               // (RULE16)
      end else if (reg_hit && is_external &&
                   state_reg != ST_SAMPLE) begin
         charge_reg <= CFG_WRITE.data;                           // (RULE12)
      end
   end

   assign charge_ports = charge_reg[CHARGE_EN_LSB +: PORTS];     // (RULE6)

   genvar p;
   generate
      for (p = 1; p <= PORTS; p++) begin : g_port
         // set by overcurrent wins over a host clear
         always_ff @(posedge CLK) begin
            if (SRST) begin
               oc_latch_reg[p] <= 1'b0;
               host_on_reg[p]  <= 1'b0;
            end else if (state_reg == ST_RUN) begin
               if (oc_sync_reg[p]) begin
                  oc_latch_reg[p] <= 1'b1;                       // (RULE17)
               end else if (HOST_POWER_REQ[p]) begin
                  oc_latch_reg[p] <= 1'b0;                       // (RULE4)
               end
               if (HOST_POWER_REQ[p] && HUB_ENUMERATED) begin
                  host_on_reg[p] <= 1'b1;
               end
            end
         end
      end
   endgenerate

   // no term on enumeration or vbus detect for charging ports
   assign power_next = (charge_ports | host_on_reg) &            // (RULE7)
                       ~oc_latch_reg & ~oc_sync_reg;             // (RULE3)

   always_ff @(posedge CLK) begin
      if (SRST) begin
         power_reg  <= '0;                                       // (RULE18)
         report_reg <= '0;
      end else begin
         power_reg  <= (state_reg == ST_RUN) ? power_next : '0;  // (RULE1)
         report_reg <= (state_reg == ST_RUN && HUB_ENUMERATED) ?  // (RULE2)
                       oc_sync_reg : '0;                         // (RULE5)
      end
   end

   assign PORT_POWER_ENABLE   = power_reg;
   assign OVER_CURRENT_REPORT = report_reg;
   assign PORT_CHARGE_ENABLE  = charge_reg;
   assign HUB_MODE            = mode_reg;
   assign CONFIG_DONE         = (state_reg == ST_RUN);

   // vbus detect kept as a port; charging power ignores it
   wire unused_vbus = UPSTREAM_VBUS_DETECT;                      // (RULE2)

endmodule : hub_port_power_config

`default_nettype wire

// [sim/switch_model.sv]
`timescale 1ns/1ps
`default_nettype none
module switch_model #(
   parameter int PORTS = 4
) (
   input  wire logic [PORTS:1] short_in,
   output logic      [PORTS:1] fault_out
);
   // fault flag stays up while the short lasts
   assign fault_out = short_in;
endmodule : switch_model
`default_nettype wire

// [sim/hpc_sva.sv]
`timescale 1ns/1ps
`default_nettype none
module hpc_sva
   import port_power_pkg::*;
#(
   parameter int PORTS = NUM_PORTS
) (
   input wire logic                      CLK,
   input wire logic                      SRST,
   input wire logic [PORTS:1]            OVER_CURRENT,
   input wire logic                      HUB_ENUMERATED,
   input wire logic [PORTS:1]            PORT_POWER_ENABLE,
   input wire logic [PORTS:1]            OVER_CURRENT_REPORT,
   input wire logic [7:0]                PORT_CHARGE_ENABLE,
   input wire port_power_pkg::hub_mode_s HUB_MODE,
   input wire logic                      CONFIG_DONE
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (SRST);
   property p_rst_off; disable iff (1'b0)
      SRST |=> !CONFIG_DONE && PORT_POWER_ENABLE == '0; endproperty
   a_rst_off: assert property (p_rst_off) else $error("on in reset");
   property p_cfg_off; !CONFIG_DONE |-> PORT_POWER_ENABLE == '0; endproperty
   a_cfg_off: assert property (p_cfg_off) else $error("on early");
   property p_oc_off; ($past(OVER_CURRENT, 4) & $past(OVER_CURRENT, 5)
      & PORT_POWER_ENABLE) == '0; endproperty
   a_oc_off: assert property (p_oc_off) else $error("on in fault");
   property p_chg_on; $rose(CONFIG_DONE) && OVER_CURRENT == '0 |-> ##2
      PORT_POWER_ENABLE == PORT_CHARGE_ENABLE[PORTS:1]; endproperty
   a_chg_on: assert property (p_chg_on) else $error("no charge");
   property p_int_keep; CONFIG_DONE && !HUB_MODE[0] |=>
      $stable(PORT_CHARGE_ENABLE); endproperty
   a_int_keep: assert property (p_int_keep) else $error("write");
   property p_mode_int; CONFIG_DONE && !HUB_MODE[0] |->
      HUB_MODE[3:1] == 3'h7; endproperty
   a_mode_int: assert property (p_mode_int) else $error("mode");
   property p_mode_ext; HUB_MODE[0] |-> !HUB_MODE[3]; endproperty
   a_mode_ext: assert property (p_mode_ext) else $error("straps");
   property p_report; (CONFIG_DONE && HUB_ENUMERATED && $stable(OVER_CURRENT))
      [*5] |-> OVER_CURRENT_REPORT == OVER_CURRENT; endproperty
   a_report: assert property (p_report) else $error("no report");
endmodule : hpc_sva
bind hub_port_power_config hpc_sva #(.PORTS(PORTS)) sva_u (.*);
`default_nettype wire

// [sim/tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb;
   import port_power_pkg::*;
   logic       clk = 0, srst = 1, ld = 0, enu = 0, done;
   logic [1:0] sel = 0;
   logic [4:1] strap = 0, shrt = 0, req = 0, oc, pwr, rpt;
   logic [7:0] chg;
   reg_write_s wr = '0;
   hub_mode_s  mode;
   int         err_total = 0, comparisons = 0;
   always #5 clk = ~clk;
   switch_model sw_u (.short_in(shrt), .fault_out(oc));
   hub_port_power_config dut_u (.CLK(clk), .SRST(srst), .CFG_SEL(sel),
      .CHARGE_ENABLE_STRAP(strap), .CFG_WRITE(wr), .CFG_LOAD_DONE(ld),
      .OVER_CURRENT(oc), .HOST_POWER_REQ(req), .HUB_ENUMERATED(enu),
      .UPSTREAM_VBUS_DETECT(1'b0), .PORT_POWER_ENABLE(pwr),
      .OVER_CURRENT_REPORT(rpt), .PORT_CHARGE_ENABLE(chg),
      .HUB_MODE(mode), .CONFIG_DONE(done));
   task automatic finish_test();
      if (err_total == 0 && comparisons > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : finish_test
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick
   task automatic boot(input logic [1:0] s, input logic [4:1] st);
      srst = 1;
      enu = 0;
      ld = 0;
      sel = s;
      strap = st;
      tick(3);
      srst = 0;
      tick(4);
   endtask : boot
   task automatic settle();
      repeat (12) if (done !== 1'b1) tick(1);
      tick(2);
   endtask : settle
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      wr = '{1'b1, a, d};
      tick(1);
      wr = '0;
      tick(1);
   endtask : wr_reg
   task automatic t_int(input logic [1:0] s, input logic [4:1] st,
                        input logic [7:0] m);
      boot(s, st);
      settle();
      chk(done, 8'h01);
      chk(pwr, {4'h0, st});
      chk(chg, {3'h0, st, 1'b0});
      chk(8'(mode), m);
      wr_reg(CHARGE_EN_OFFSET, 8'hFF);
      tick(1);
      chk(chg, {3'h0, st, 1'b0});
      chk(pwr, {4'h0, st});
   endtask : t_int
   task automatic t_ext(input logic [1:0] s);
      boot(s, 4'hF);
      wr_reg(CHARGE_EN_OFFSET, 8'h0C);
      wr_reg(8'hD1, 8'h3E);
      chk(chg, 8'h0C);
      chk(pwr, 8'h00);
      chk(done, 8'h00);
      ld = 1;
      settle();
      chk(done, 8'h01);
      chk(pwr, 8'h06);
      chk({mode.strap_enabled, mode.external_cfg}, 8'h01);
   endtask : t_ext
   task automatic t_oc();
      boot(2'h0, 4'h7);
      settle();
      shrt = 4'h2;
      tick(6);
      chk(pwr, 8'h05);
      chk(rpt, 8'h00);
      shrt = 4'h0;
      tick(6);
      chk(pwr, 8'h05);
      req = 4'h2;
      tick(1);
      req = 4'h0;
      tick(4);
      chk(pwr, 8'h07);
      enu = 1;
      shrt = 4'h4;
      tick(6);
      chk(rpt, 8'h04);
      chk(pwr, 8'h03);
      req = 4'h4;
      tick(1);
      req = 4'h0;
      shrt = 4'h0;
      tick(6);
      chk(rpt, 8'h00);
      chk(pwr, 8'h03);
      req = 4'hC;
      tick(1);
      req = 4'h0;
      tick(4);
      chk(pwr, 8'h0F);
   endtask : t_oc
   initial begin
      t_int(2'h0, 4'h5, 8'h1E);
      t_ext(2'h1);
      t_ext(2'h3);
      t_oc();
      t_int(2'h2, 4'h6, 8'h0E);
      finish_test();
   end
   initial begin
      #20000;
      err_total++;
      finish_test();
   end
endmodule : tb
`default_nettype wire
